// ### hw/sp_params.svh
// constants of the host-side packet link controller
// assumes a 20 MHz system clock and an 8N1 asynchronous serial line
`ifndef SP_PARAMS_SVH
`define SP_PARAMS_SVH

// ----------------------------------------------------------------
// clock and line rates
// ----------------------------------------------------------------
`define SP_CLK_HZ 20000000
`define SP_BAUD_SLOW 19200
`define SP_BAUD_FAST 115200
`define SP_BIT_CYC_SLOW (`SP_CLK_HZ / `SP_BAUD_SLOW)
`define SP_BIT_CYC_FAST (`SP_CLK_HZ / `SP_BAUD_FAST)

// ----------------------------------------------------------------
// acknowledge timing and retries
// ----------------------------------------------------------------
`define SP_ACK_TMO_MS 250
`define SP_ACK_TMO_CYC ((`SP_CLK_HZ / 1000) * `SP_ACK_TMO_MS)
`define SP_RETRIES 3

// ----------------------------------------------------------------
// packet layout
// ----------------------------------------------------------------
`define SP_MAX_LEN 18
`define SP_PING_MAX 16
`define SP_NV_LEN 16
`define SP_CAT_POS 6
`define SP_CODE_PING 6'h00
`define SP_CODE_VER 6'h01
`define SP_CODE_NVWR 6'h02
`define SP_CODE_NVRD 6'h03
`define SP_CRC_INIT 16'hFFFF
`define SP_CRC_POLY 16'h8408

`endif

// ### hw/sp_pkg.sv
// types shared by the packet link controller files
// assumes sp_params.svh for numeric constants
package sp_pkg;

  // packet category held in the top two type bits
  typedef enum logic [1:0] {
    SP_CAT_CMD = 2'b00,
    SP_CAT_RSP = 2'b01,
    SP_CAT_RPT = 2'b10,
    SP_CAT_ERR = 2'b11
  } sp_cat_e;

  typedef struct packed {
    sp_cat_e cat;
    logic [5:0] code;
  } sp_type_s;

  // one whole packet, payload byte i at data[8*i +: 8]
  typedef struct packed {
    sp_type_s ptype;
    logic [7:0] len;
    logic [143:0] data;
  } sp_pkt_s;

  // transmit sequence, gray coded along the path
  typedef enum logic [2:0] {
    SP_TX_IDLE = 3'b000,
    SP_TX_TYPE = 3'b001,
    SP_TX_LEN = 3'b011,
    SP_TX_DATA = 3'b010,
    SP_TX_CRCL = 3'b110,
    SP_TX_CRCH = 3'b111,
    SP_TX_WAIT = 3'b101
  } sp_tx_e;

  // receive parser
  typedef enum logic [2:0] {
    SP_RX_TYPE = 3'b000,
    SP_RX_LEN = 3'b001,
    SP_RX_DATA = 3'b011,
    SP_RX_CRCL = 3'b010,
    SP_RX_CRCH = 3'b110
  } sp_rx_e;

endpackage

// ### hw/sp_uart.sv
// byte serialiser and deserialiser, 8 data bits, no parity, one stop
// assumes ser_rx synchronous to clk_sys; bit_cyc steady between bytes
`timescale 1ns/100ps

module sp_uart (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [15:0] bit_cyc,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  output logic ser_tx,
  input wire logic ser_rx,
  output logic rx_valid,
  output logic [7:0] rx_data
);

  logic [15:0] tx_cnt_r;
  logic [3:0] tx_bit_r;
  logic [9:0] tx_sh_r;
  logic tx_busy_r;
  logic [15:0] rx_cnt_r;
  logic [3:0] rx_bit_r;
  logic rx_busy_r;
  logic tx_tick;
  logic rx_tick;

  // ----------------------------------------------------------------
  // bit timing
  // ----------------------------------------------------------------
  assign tx_tick = (tx_cnt_r == bit_cyc - 16'h0001);
  assign rx_tick = (rx_cnt_r == bit_cyc - 16'h0001);
  assign tx_ready = !tx_busy_r;
  assign ser_tx = tx_sh_r[0]; // idles high from the shifter

  // transmit shifter: start, 8 bits lsb first, stop
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tx_busy_r <= 1'b0;
      tx_cnt_r <= 16'h0000;
      tx_bit_r <= 4'h0;
      tx_sh_r <= 10'h3FF;
    end else if (ce) begin
      if (!tx_busy_r && tx_valid) begin
        tx_busy_r <= 1'b1;
        tx_cnt_r <= 16'h0000;
        tx_bit_r <= 4'h0;
        tx_sh_r <= {1'b1, tx_data, 1'b0};
      end else if (tx_busy_r) begin
        tx_cnt_r <= tx_tick ? 16'h0000 : tx_cnt_r + 16'h0001;
        if (tx_tick) begin
          tx_sh_r <= {1'b1, tx_sh_r[9:1]};
          tx_bit_r <= tx_bit_r + 4'h1;
          if (tx_bit_r == 4'h9) begin
            tx_busy_r <= 1'b0;
          end
        end
      end
    end
  end

  // receive sampler, aligned to mid-bit from the start edge
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rx_busy_r <= 1'b0;
      rx_cnt_r <= 16'h0000;
      rx_bit_r <= 4'h0;
      rx_data <= 8'h00;
      rx_valid <= 1'b0;
    end else if (ce) begin
      rx_valid <= 1'b0;
      if (!rx_busy_r) begin
        if (!ser_rx) begin
          rx_busy_r <= 1'b1;
          rx_cnt_r <= {1'b0, bit_cyc[15:1]};
          rx_bit_r <= 4'h0;
        end
      end else begin
        rx_cnt_r <= rx_tick ? 16'h0000 : rx_cnt_r + 16'h0001;
        if (rx_tick) begin
          rx_bit_r <= rx_bit_r + 4'h1;
          if (rx_bit_r == 4'h0 && ser_rx) begin
            rx_busy_r <= 1'b0; // glitch, not a start bit
          end else if (rx_bit_r == 4'h9) begin
            rx_busy_r <= 1'b0;
            rx_valid <= ser_rx; // framing error drops the byte
          end else if (rx_bit_r != 4'h0) begin
            rx_data <= {ser_rx, rx_data[7:1]};
          end
        end
      end
    end
  end

endmodule

// ### hw/sp_host.sv
// host-side controller of a display module's framed serial link
// assumes one 20 MHz clock, sync reset, the module on ser_tx/ser_rx
//
// Summary of operation
// RULE_01: packet is type, length, payload, checksum
// RULE_02: type holds category bits and six-bit code
// RULE_03: categories command, response, report, error
// RULE_04: payload length never above eighteen
// RULE_05: sixteen-bit CRC over type, length, payload
// RULE_06: CRC low byte first, right after payload
// RULE_07: device acknowledges each command within 250 ms
// RULE_08: host waits for acknowledge before next command
// RULE_09: host resends after 250 ms, errors after retries
// RULE_10: host buffers several packets, drains them fast
// RULE_11: reports arrive anytime; classify by type field
// RULE_12: key reports type 0x80, codes 1 to 12
// RULE_13: only enabled key events are reported
// RULE_14: fan reports type 0x81 every half second
// RULE_15: temperature reports type 0x82 every second
// RULE_16: answer code equals command code
// RULE_17: ping echoes up to sixteen payload bytes
// RULE_18: version query returns sixteen text bytes
// RULE_19: user area write always carries sixteen bytes
// RULE_20: user area read returns stored contents
// RULE_21: line 19200 8N1, 115200 selectable
// RULE_22: bad length or CRC dropped, then resync
// RULE_23: non-command packets ignored by the device
`timescale 1ns/100ps
`include "sp_params.svh"

module sp_host #(
  parameter int unsigned ACK_TMO_CYC = `SP_ACK_TMO_CYC,
  parameter int unsigned RETRIES = `SP_RETRIES,
  parameter int unsigned DEPTH = 4
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic baud_fast,
  input wire logic ser_rx,
  output logic ser_tx,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire sp_pkg::sp_pkt_s cmd,
  output logic cmd_done,
  output logic cmd_fail,
  output logic rsp_valid,
  input wire logic rsp_ready,
  output sp_pkg::sp_pkt_s rsp,
  output logic rx_drop
);

  localparam int AW = $clog2(DEPTH);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // one byte of the reflected 16-bit CRC
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ b[i]) ? ((r >> 1) ^ `SP_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // legal payload length for the command code
  function automatic logic [7:0] fix_len(input logic [5:0] code, input logic [7:0] len);
    if (code == `SP_CODE_NVWR) begin
      return 8'(`SP_NV_LEN); // [RULE_19]
    end else if (code == `SP_CODE_VER || code == `SP_CODE_NVRD) begin
      return 8'h00; // [RULE_18] [RULE_20]
    end else if (code == `SP_CODE_PING && len > 8'(`SP_PING_MAX)) begin
      return 8'(`SP_PING_MAX); // [RULE_17]
    end else if (len > 8'(`SP_MAX_LEN)) begin
      return 8'(`SP_MAX_LEN); // [RULE_04]
    end
    return len;
  endfunction

  sp_pkg::sp_tx_e tx_st_r;
  sp_pkg::sp_pkt_s cmd_r;
  logic [4:0] idx_r;
  logic [15:0] crc_r;
  logic [31:0] tmo_r;
  logic [7:0] try_r;
  sp_pkg::sp_rx_e rx_st_r;
  sp_pkg::sp_pkt_s in_r;
  logic [4:0] rx_idx_r;
  logic [15:0] rx_crc_r;
  logic [7:0] rx_crcl_r;
  sp_pkg::sp_pkt_s mem [DEPTH];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0] cnt_r;

  logic [15:0] bit_cyc;
  logic [7:0] tx_byte;
  logic tx_valid;
  logic tx_ready;
  logic tx_go;
  logic [7:0] rx_byte;
  logic rx_valid;
  logic [15:0] crc_out;
  logic pkt_good;
  logic pkt_ack;
  logic tmo_hit;
  logic push;
  logic pop;
  logic full;

  // ----------------------------------------------------------------
  // line interface
  // ----------------------------------------------------------------
  assign bit_cyc = baud_fast ? 16'(`SP_BIT_CYC_FAST) : 16'(`SP_BIT_CYC_SLOW); // [RULE_21]

  sp_uart u_uart (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ce(ce),
    .bit_cyc(bit_cyc),
    .tx_valid(tx_valid),
    .tx_data(tx_byte),
    .tx_ready(tx_ready),
    .ser_tx(ser_tx),
    .ser_rx(ser_rx),
    .rx_valid(rx_valid),
    .rx_data(rx_byte)
  );

  // ----------------------------------------------------------------
  // transmit path
  // ----------------------------------------------------------------
  // byte on offer in each step of the packet
  assign crc_out = ~crc_r;
  assign tx_byte = (tx_st_r == sp_pkg::SP_TX_TYPE) ? cmd_r.ptype :
                   (tx_st_r == sp_pkg::SP_TX_LEN) ? cmd_r.len :
                   (tx_st_r == sp_pkg::SP_TX_DATA) ? cmd_r.data[{idx_r, 3'b000} +: 8] :
                   (tx_st_r == sp_pkg::SP_TX_CRCL) ? crc_out[7:0] : // [RULE_06]
                   crc_out[15:8];
  assign tx_valid = (tx_st_r != sp_pkg::SP_TX_IDLE) && (tx_st_r != sp_pkg::SP_TX_WAIT);
  assign tx_go = tx_valid && tx_ready;
  assign cmd_ready = (tx_st_r == sp_pkg::SP_TX_IDLE); // [RULE_08]
  assign tmo_hit = (tmo_r == ACK_TMO_CYC - 1);

  // send, await acknowledge, resend on silence
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tx_st_r <= sp_pkg::SP_TX_IDLE;
      cmd_r <= '0;
      idx_r <= 5'h00;
      crc_r <= `SP_CRC_INIT;
      tmo_r <= 32'h0000_0000;
      try_r <= 8'h00;
      cmd_done <= 1'b0;
      cmd_fail <= 1'b0;
    end else if (ce) begin
      cmd_done <= 1'b0;
      cmd_fail <= 1'b0;
      if (tx_go && tx_st_r != sp_pkg::SP_TX_CRCL && tx_st_r != sp_pkg::SP_TX_CRCH) begin
        crc_r <= crc_step(crc_r, tx_byte); // [RULE_05]
      end
      unique case (tx_st_r)
        sp_pkg::SP_TX_IDLE: begin
          if (cmd_valid) begin
            cmd_r.ptype.cat <= sp_pkg::SP_CAT_CMD; // [RULE_03]
            cmd_r.ptype.code <= cmd.ptype.code; // [RULE_02]
            cmd_r.len <= fix_len(cmd.ptype.code, cmd.len);
            cmd_r.data <= cmd.data;
            try_r <= 8'h00;
            crc_r <= `SP_CRC_INIT;
            tx_st_r <= sp_pkg::SP_TX_TYPE; // [RULE_01]
          end
        end
        sp_pkg::SP_TX_TYPE: if (tx_go) tx_st_r <= sp_pkg::SP_TX_LEN;
        sp_pkg::SP_TX_LEN: begin
          if (tx_go) begin
            idx_r <= 5'h00;
            tx_st_r <= (cmd_r.len == 8'h00) ? sp_pkg::SP_TX_CRCL : sp_pkg::SP_TX_DATA;
          end
        end
        sp_pkg::SP_TX_DATA: begin
          if (tx_go) begin
            idx_r <= idx_r + 5'h01;
            if ({3'b000, idx_r} == cmd_r.len - 8'h01) tx_st_r <= sp_pkg::SP_TX_CRCL; // [RULE_06]
          end
        end
        sp_pkg::SP_TX_CRCL: if (tx_go) tx_st_r <= sp_pkg::SP_TX_CRCH;
        sp_pkg::SP_TX_CRCH: begin
          if (tx_go) begin
            tmo_r <= 32'h0000_0000;
            tx_st_r <= sp_pkg::SP_TX_WAIT;
          end
        end
        sp_pkg::SP_TX_WAIT: begin
          tmo_r <= tmo_r + 32'h0000_0001;
          if (pkt_ack) begin
            cmd_done <= 1'b1;
            tx_st_r <= sp_pkg::SP_TX_IDLE;
          end else if (tmo_hit) begin // [RULE_09]
            crc_r <= `SP_CRC_INIT;
            if (try_r == 8'(RETRIES)) begin
              cmd_fail <= 1'b1;
              tx_st_r <= sp_pkg::SP_TX_IDLE;
            end else begin
              try_r <= try_r + 8'h01;
              tx_st_r <= sp_pkg::SP_TX_TYPE;
            end
          end
        end
        default: tx_st_r <= sp_pkg::SP_TX_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // receive path
  // ----------------------------------------------------------------
  // a packet is good when both checksum bytes match
  assign pkt_good = rx_valid && (rx_st_r == sp_pkg::SP_RX_CRCH) &&
                    ({rx_byte, rx_crcl_r} == ~rx_crc_r); // [RULE_05] [RULE_06]
  // only a response or error with the awaited code acknowledges; otherwise the timeout ends the wait
  assign pkt_ack = pkt_good && (tx_st_r == sp_pkg::SP_TX_WAIT) &&
                   (in_r.ptype.cat == sp_pkg::SP_CAT_RSP ||
                    in_r.ptype.cat == sp_pkg::SP_CAT_ERR) &&
                   (in_r.ptype.code == cmd_r.ptype.code); // [RULE_11] [RULE_16]

  // parser; a bad packet restarts the hunt at the next byte
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rx_st_r <= sp_pkg::SP_RX_TYPE;
      in_r <= '0;
      rx_idx_r <= 5'h00;
      rx_crc_r <= `SP_CRC_INIT;
      rx_crcl_r <= 8'h00;
      rx_drop <= 1'b0;
    end else if (ce) begin
      rx_drop <= 1'b0;
      if (rx_valid) begin
        unique case (rx_st_r)
          sp_pkg::SP_RX_TYPE: begin
            in_r <= '0;
            in_r.ptype <= rx_byte;
            rx_crc_r <= crc_step(`SP_CRC_INIT, rx_byte);
            rx_st_r <= sp_pkg::SP_RX_LEN;
          end
          sp_pkg::SP_RX_LEN: begin
            rx_idx_r <= 5'h00;
            rx_crc_r <= crc_step(rx_crc_r, rx_byte);
            in_r.len <= rx_byte;
            if (rx_byte > 8'(`SP_MAX_LEN)) begin
              rx_drop <= 1'b1; // [RULE_04] [RULE_22]
              rx_st_r <= sp_pkg::SP_RX_TYPE;
            end else begin
              rx_st_r <= (rx_byte == 8'h00) ? sp_pkg::SP_RX_CRCL : sp_pkg::SP_RX_DATA;
            end
          end
          sp_pkg::SP_RX_DATA: begin
            in_r.data[{rx_idx_r, 3'b000} +: 8] <= rx_byte;
            rx_crc_r <= crc_step(rx_crc_r, rx_byte);
            rx_idx_r <= rx_idx_r + 5'h01;
            if ({3'b000, rx_idx_r} == in_r.len - 8'h01) rx_st_r <= sp_pkg::SP_RX_CRCL;
          end
          sp_pkg::SP_RX_CRCL: begin
            rx_crcl_r <= rx_byte;
            rx_st_r <= sp_pkg::SP_RX_CRCH;
          end
          sp_pkg::SP_RX_CRCH: begin
            rx_drop <= !pkt_good || full; // [RULE_22]
            rx_st_r <= sp_pkg::SP_RX_TYPE;
          end
          default: rx_st_r <= sp_pkg::SP_RX_TYPE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // incoming packet queue
  // ----------------------------------------------------------------
  assign full = (cnt_r == (AW+1)'(DEPTH));
  assign push = ce && pkt_good && !full; // [RULE_10]
  assign pop = ce && rsp_valid && rsp_ready;
  assign rsp_valid = (cnt_r != '0);
  assign rsp = mem[rd_r];

  // queue storage and pointers
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        mem[wr_r] <= in_r;
        wr_r <= (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + AW'(1);
      end
      if (pop) rd_r <= (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + AW'(1);
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule

// ### sim/sp_host_chk.sv
// checker of the host link controller, sees only its ports
// assumes one clock domain and the bind at the foot of this file
`timescale 1ns/100ps

module sp_host_chk #(
  parameter int unsigned ACK_TMO_CYC = 5000000,
  parameter int unsigned RETRIES = 3
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic cmd_done,
  input wire logic cmd_fail,
  input wire logic ser_tx,
  input wire logic rsp_valid,
  input wire logic rsp_ready,
  input wire sp_pkg::sp_pkt_s rsp,
  input wire logic rx_drop
);
  // worst case: every try sends the longest packet at the slow rate
  localparam int unsigned LIM = (RETRIES + 1) * (ACK_TMO_CYC + 230000);
  logic [31:0] cyc_r;
  logic [31:0] cyc_nxt;

  // --------
  // cycles since the last command was taken
  // --------
  assign cyc_nxt = (cmd_valid && cmd_ready) ? 32'h0000_0000 : cyc_r + 32'h0000_0001;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) cyc_r <= 32'h0000_0000;
    else if (ce) cyc_r <= cyc_nxt;
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // --------
  // properties
  // --------
  AST_TAKE_BUSY: assert property (ce && cmd_valid && cmd_ready |=> !cmd_ready)
    else $error("command port stayed ready after a take");
  AST_READY_ON_ANSWER: assert property ($rose(cmd_ready) |-> cmd_done || cmd_fail)
    else $error("command port ready again without an answer");
  AST_ANSWER_PULSE: assert property (cmd_done || cmd_fail |=> !cmd_done && !cmd_fail)
    else $error("answer pulse longer than one cycle");
  AST_ONE_ANSWER: assert property (!(cmd_done && cmd_fail))
    else $error("done and fail together");
  AST_IDLE_LINE: assert property (cmd_ready |-> ser_tx)
    else $error("serial line not idle while no command outstanding");
  AST_START_SOON: assert property (ce && cmd_valid && cmd_ready |-> ##[1:3] !ser_tx)
    else $error("no start bit after a take");
  AST_FAIL_LATE: assert property (cmd_fail |-> cyc_r >= (RETRIES + 1) * ACK_TMO_CYC)
    else $error("failure before all waits ran out");
  AST_ANSWER_BOUND: assert property (!cmd_ready |-> cyc_r < LIM)
    else $error("command outstanding too long");
  AST_RSP_HOLD: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp))
    else $error("queued packet changed before it was taken");
  AST_RSP_LEN: assert property (rsp_valid |-> rsp.len <= 8'h12)
    else $error("queued packet longer than the limit");
  AST_DROP_PULSE: assert property (rx_drop |=> !rx_drop)
    else $error("drop pulse longer than one cycle");
endmodule

bind sp_host sp_host_chk #(.ACK_TMO_CYC(ACK_TMO_CYC), .RETRIES(RETRIES)) i_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
  .cmd_done(cmd_done), .cmd_fail(cmd_fail), .ser_tx(ser_tx), .rsp_valid(rsp_valid),
  .rsp_ready(rsp_ready), .rsp(rsp), .rx_drop(rx_drop));

// ### sim/sp_dev_model.sv
// behavioural display module on the far end of the serial link
// assumes 8N1 at BIT cycles per bit; reports are pushed by the bench
`timescale 1ns/100ps

module sp_dev_model #(
  parameter int BIT = 173,
  parameter logic [127:0] VER = 128'h0
) (
  input wire logic clk_sys,
  input wire logic line_in,
  output logic line_out,
  input wire logic mute
);
  logic [7:0] tx_q[$];
  logic [7:0] nv[16];
  int n_rx = 0;
  int n_bad = 0;
  logic [7:0] last_len = 8'h00;
  logic [12:1] key_en = 12'hfff; // key events enabled for reporting

  // reflected checksum, inverted on the line
  function automatic logic [15:0] crc_f(input logic [7:0] b[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (b[i]) for (int k = 0; k < 8; k++)
      c = (c[0] ^ b[i][k]) ? (c >> 1) ^ 16'h8408 : c >> 1;
    return ~c;
  endfunction

  // whole packet into the send queue, bad flips the low bit of the checksum
  task automatic push(input logic [7:0] ty, input logic [7:0] d[$], input logic bad);
    logic [7:0] p[$];
    logic [15:0] c;
    p.push_back(ty); // category and code
    p.push_back(8'(d.size())); // payload count
    foreach (d[i]) p.push_back(d[i]);
    c = crc_f(p) ^ {15'h0000, bad};
    foreach (p[i]) tx_q.push_back(p[i]);
    tx_q.push_back(c[7:0]); // low byte right after payload
    tx_q.push_back(c[15:8]);
  endtask

  // key event report, sent only when that event is enabled
  task automatic key(input logic [7:0] k);
    logic [7:0] d[$];
    d = {k};
    if (k inside {[8'h01:8'h0c]} && key_en[k]) push(8'h80, d, 1'b0);
  endtask

  // --------
  // line driver, idle at mark level
  // --------
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line_out <= f[i]; // 8N1 framing
      repeat (BIT) @(posedge clk_sys);
    end
  endtask

  initial begin
    line_out = 1'b1;
    forever begin
      @(posedge clk_sys);
      if (tx_q.size() > 0) send(tx_q.pop_front()); // reports interleave freely
    end
  end

  // --------
  // receiver and command handling
  // --------
  task automatic get(output logic [7:0] b);
    @(negedge line_in);
    repeat (BIT / 2) @(posedge clk_sys);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge clk_sys);
      b[i] = line_in;
    end
    repeat (BIT) @(posedge clk_sys);
  endtask

  task automatic reply(input logic [5:0] code, input logic [7:0] d[$]);
    logic [7:0] r[$];
    case (code)
      6'h00: r = d; // echo
      6'h01: for (int i = 0; i < 16; i++) r.push_back(VER[127-8*i -: 8]);
      6'h02: foreach (nv[i]) nv[i] = d[i];
      6'h03: foreach (nv[i]) r.push_back(nv[i]);
      default: ;
    endcase
    push({2'b01, code}, r, 1'b0); // same code, answered at once
  endtask

  initial begin
    forever begin
      logic [7:0] ty, ln, cl, ch, b;
      logic [7:0] d[$];
      logic [7:0] p[$];
      d = {};
      get(ty);
      get(ln);
      last_len = ln; // length as the host sent it
      for (int i = 0; i < ln; i++) begin
        get(b);
        d.push_back(b);
      end
      get(cl);
      get(ch);
      p = d;
      p.push_front(ln);
      p.push_front(ty);
      n_rx++;
      if (crc_f(p) !== {ch, cl}) n_bad++; // bad packet dropped
      else if (ty[7:6] == 2'b00 && !mute) reply(ty[5:0], d); // non-commands ignored
    end
  end
endmodule

// ### sim/tb.sv
// self-checking bench of the host link controller with a device model
// assumes fast line rate and short acknowledge wait for run time
`timescale 1ns/100ps

module tb;
  localparam int TMO = 38000; // covers a sixteen byte answer at the fast rate
  localparam int RET = 0; // one try keeps the silent case short
  localparam logic [127:0] VER = 128'h5445_5354_2d52_4556_2d30_312e_3030_2020; // arbitrary
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic rsp_ready = 1'b0;
  logic mute = 1'b0;
  logic ser_rx, ser_tx, cmd_ready, cmd_done, cmd_fail, rsp_valid, rx_drop;
  sp_pkg::sp_pkt_s cmd = '0;
  sp_pkg::sp_pkt_s rsp;
  sp_pkg::sp_pkt_s exp_q[$];
  int n_errors = 0;
  int n_tests = 0;
  int n_drop = 0;
  int seed = 47182;
  int cyc = 0;

  sp_host #(.ACK_TMO_CYC(TMO), .RETRIES(RET), .DEPTH(4)) i_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .ce(1'b1), .baud_fast(1'b1), .ser_rx(ser_rx),
    .ser_tx(ser_tx), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
    .cmd_done(cmd_done), .cmd_fail(cmd_fail), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
    .rsp(rsp), .rx_drop(rx_drop));
  sp_dev_model #(.BIT(173), .VER(VER)) i_dev (
    .clk_sys(clk_sys), .line_in(ser_tx), .line_out(ser_rx), .mute(mute));

  // --------
  // helpers
  // --------
  function automatic sp_pkg::sp_pkt_s mk(input sp_pkg::sp_cat_e c, input logic [5:0] k,
      input logic [7:0] n, input logic [143:0] d);
    mk = '{ptype: '{cat: c, code: k}, len: n, data: d};
  endfunction

  task automatic cmp_pkt(input string what, input sp_pkg::sp_pkt_s e, input sp_pkg::sp_pkt_s g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic cmp_val(input string what, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic print_verdict();
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // one command, then a bounded wait for its answer
  task automatic run_cmd(input logic [5:0] k, input logic [7:0] n, input logic [143:0] d,
      input logic want);
    int w;
    cmd = mk(sp_pkg::SP_CAT_CMD, k, n, d);
    cmd_valid = 1'b1;
    @(posedge clk_sys);
    #1;
    cmd_valid = 1'b0;
    cmp_val("busy", 32'h0, 32'(cmd_ready));
    w = 0;
    while (cmd_done !== 1'b1 && cmd_fail !== 1'b1 && w < 60000) begin
      @(posedge clk_sys);
      #1;
      w++;
    end
    cmp_val("answer", 32'({want, !want}), 32'({cmd_done, cmd_fail}));
  endtask

  // --------
  // clock, timeout, consumer and monitor
  // --------
  initial begin
    forever #25 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    rsp_ready <= #1 1'($random(seed));
    if (cyc == 130000) begin
      n_errors++;
      print_verdict();
    end
  end

  // pop happens at the coming edge, so compare now
  always @(negedge clk_sys) begin
    if (rst_n && rx_drop === 1'b1) n_drop++; // drop pulses last one cycle
    if (rst_n && rsp_valid === 1'b1 && rsp_ready === 1'b1) begin
      if (exp_q.size() > 0) cmp_pkt("rsp", exp_q.pop_front(), rsp);
      else begin
        n_errors++;
        $display("FAIL rsp expected none seen %h", rsp);
      end
    end
  end

  // --------
  // scenarios
  // --------
  initial begin
    logic [7:0] q[$];
    logic [7:0] k, b;
    logic [143:0] vd;
    int n;
    vd = '0;
    repeat (6) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    // key report overtakes the answer to a one byte ping
    b = 8'($random(seed));
    k = 8'(($random(seed) & 32'h7fff_ffff) % 12 + 1);
    i_dev.key(k);
    exp_q.push_back(mk(sp_pkg::SP_CAT_RPT, 6'h00, 8'h01, {136'h0, k}));
    exp_q.push_back(mk(sp_pkg::SP_CAT_RSP, 6'h00, 8'h01, {136'h0, b}));
    run_cmd(6'h00, 8'h01, {136'h0, b}, 1'b1);
    // revision query, sixteen byte answer
    for (int i = 0; i < 16; i++) vd[8*i +: 8] = VER[127-8*i -: 8];
    exp_q.push_back(mk(sp_pkg::SP_CAT_RSP, 6'h01, 8'h10, vd));
    run_cmd(6'h01, 8'h00, '0, 1'b1);
    // bad checksum, a disabled key, then good reports must still be found
    q = {8'h05};
    i_dev.push(8'h80, q, 1'b1);
    i_dev.key_en[7] = 1'b0;
    i_dev.key(8'h07); // no report expected
    i_dev.key(8'h0b);
    q = {8'h01, 8'h2a};
    i_dev.push(8'h81, q, 1'b0); // fan report
    q = {8'h03, 8'h19};
    i_dev.push(8'h82, q, 1'b0); // temperature report
    exp_q.push_back(mk(sp_pkg::SP_CAT_RPT, 6'h00, 8'h01, {136'h0, 8'h0b}));
    exp_q.push_back(mk(sp_pkg::SP_CAT_RPT, 6'h01, 8'h02, {128'h0, 8'h2a, 8'h01}));
    exp_q.push_back(mk(sp_pkg::SP_CAT_RPT, 6'h02, 8'h02, {128'h0, 8'h19, 8'h03}));
    // silent device while the reports stream in: one try, then give up
    mute = 1'b1;
    n = i_dev.n_rx;
    run_cmd(6'h03, 8'h05, '0, 1'b0);
    cmp_val("tries", 32'(n + RET + 1), 32'(i_dev.n_rx));
    cmp_val("rdlen", 32'h0, 32'(i_dev.last_len));
    cmp_val("drop", 32'h1, 32'(n_drop));
    mute = 1'b0;
    cmp_val("crc", 32'h0, 32'(i_dev.n_bad));
    cmp_val("left", 32'h0, 32'(exp_q.size()));
    print_verdict();
  end
endmodule
